// file: inc/pmc_pkg.sv
// shared constants, types and helpers for the loop mode control block
package pmc_pkg;
	// control word map
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam int CTRL_W = 16;
	localparam int ISO_BIT = 15;
	localparam int IAI_BIT = 14;
	localparam int RELOCK_BIT = 13;
	localparam int TEST_BIT = 12;
	localparam int MULT_HI = 11;
	localparam int MULT_LO = 7;
	localparam int DIV_HI = 6;
	localparam int DIV_LO = 5;
	localparam int LOCKREQ_BIT = 4;
	localparam int BYP_HI = 3;
	localparam int BYP_LO = 2;
	localparam int INTACT_BIT = 1;
	localparam int STATUS_BIT = 0;
	// power-on value: only relock-on-loss is set
	localparam logic [15:0] CTRL_RST = 16'h2000;
	// bits software may change; bits 1 and 0 are status
	localparam logic [15:0] CTRL_WMASK = 16'hfffc;
	localparam logic [4:0] MULT_SYNTH_MIN = 5'h02;

	typedef enum logic [1:0] {
		PMC_BYPASS = 2'b00,
		PMC_LOCKING = 2'b01,
		PMC_LOCKED = 2'b10
	} pmc_state_t;

	// lock divider code n divides by n+1
	function automatic logic [2:0] pmc_ref_ratio(input logic [1:0] code);
		pmc_ref_ratio = {1'b0, code} + 3'h1;
	endfunction

	// bypass code: 00 -> 1, 01 -> 2, 1x -> 4
	function automatic logic [2:0] pmc_byp_ratio(input logic [1:0] code);
		if (code[1]) begin
			pmc_byp_ratio = 3'h4;
		end else if (code[0]) begin
			pmc_byp_ratio = 3'h2;
		end else begin
			pmc_byp_ratio = 3'h1;
		end
	endfunction
endpackage

// file: verilog/pmc_tick_div.sv
// reference divider producing one enable pulse per output period
`timescale 1ns/1ps
`default_nettype none
module pmc_tick_div (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic [2:0] ratio_in,
	input wire logic restart_in,
	output logic tick_out
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	// count 0..ratio-1, pulse on the last count
	always_comb begin
		if (restart_in || cnt_q >= ratio_in - 3'h1) begin
			cnt_d = 3'h0;
		end else begin
			cnt_d = cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// ratio change mid-period ends the period early but never emits a double pulse
	assign tick_out = !restart_in && (cnt_q >= ratio_in - 3'h1);
endmodule
`default_nettype wire

// file: verilog/pmc_tick_switch.sv
// glitch-free selector between two output-clock enable streams
`timescale 1ns/1ps
`default_nettype none
module pmc_tick_switch (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic sel_in,
	input wire logic tick_byp_in,
	input wire logic tick_lock_in,
	output logic tick_out,
	output logic cur_sel_out
);
	logic cur_q;
	logic cur_d;

	// change source only on a period boundary of the current source
	always_comb begin
		cur_d = cur_q;
		if (sel_in != cur_q) begin
			if (cur_q ? tick_lock_in : tick_byp_in) begin
				cur_d = sel_in;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cur_q <= 1'b0;
		end else begin
			cur_q <= cur_d;
		end
	end

	// a dead source would stall the switch, so bypass is always enabled below
	assign tick_out = cur_q ? tick_lock_in : tick_byp_in;
	assign cur_sel_out = cur_q;
endmodule
`default_nettype wire

// file: verilog/pmc_top.sv
// loop mode control wrapper: control word, lock sequencing and output clock selection
// Overview of operation
// - five-bit multiplier in bits 11:7; codes 0 and 1 mean factor one
// - two-bit reference divider in bits 6:5 divides by code plus one
// - lock mode with multiplier 2..31 outputs multiplier over divider times reference
// - lock request bit 4: clear gives bypass, set starts locking sequence
// - lock mode only after request set and locking complete; else bypass
// - bypass output is reference divided by 1, 2 or 4 per bits 3:2
// - bypass clock keeps running while the loop is locking
// - bit 1 clears on lock loss; sets on relock or control write
// - bit 0 shows lock status: 0 bypass or locking, 1 lock mode with any multiplier code
// - isolation bit grounds level-shifter outputs; clear passes them; resets 0
// - any control write drops to bypass, then relocks or stays per contents
// - relock bit 13, reset 1: on loss go bypass and relock; else hold
`timescale 1ns/1ps
`default_nettype none
module pmc_top (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	output logic [15:0] reg_rdata_out,
	input wire logic core_lock_in,
	input wire logic core_synth_clk_in,
	output logic core_enable_out,
	output logic [4:0] core_mult_out,
	output logic [1:0] core_div_out,
	output logic core_iso_out,
	output logic clkout_en_out,
	output logic clkout_src_out,
	output logic lock_status_out
);
	// control word storage (bits 1:0 are status and not stored here)
	logic [15:0] ctrl_q;
	logic [15:0] ctrl_d;
	logic intact_q;
	logic intact_d;
	pmc_pkg::pmc_state_t state_q;
	pmc_pkg::pmc_state_t state_d;

	// synchronisers for the core's pins
	logic lock_m_q;
	logic lock_s_q;
	logic lock_p_q;
	logic synth_m_q;
	logic synth_s_q;
	logic synth_p_q;

	// field views
	logic iso;
	logic relock_on_loss;
	logic lock_req;
	logic [4:0] feedback_multiplier;
	logic [1:0] ref_divider;
	logic [1:0] byp_div;
	logic lock_ok;
	logic lock_rise;
	logic lock_fall;
	logic synth_tick;
	logic tick_byp;
	logic tick_refdiv;
	logic tick_lock;
	logic restart_div;
	logic lock_sel;

	assign iso = ctrl_q[pmc_pkg::ISO_BIT];
	assign relock_on_loss = ctrl_q[pmc_pkg::RELOCK_BIT];
	assign lock_req = ctrl_q[pmc_pkg::LOCKREQ_BIT];
	assign feedback_multiplier = ctrl_q[pmc_pkg::MULT_HI:pmc_pkg::MULT_LO];
	assign ref_divider = ctrl_q[pmc_pkg::DIV_HI:pmc_pkg::DIV_LO];
	assign byp_div = ctrl_q[pmc_pkg::BYP_HI:pmc_pkg::BYP_LO];

	// two-stage capture of the core's lock and synthesized clock
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			lock_m_q <= 1'b0;
			lock_s_q <= 1'b0;
			lock_p_q <= 1'b0;
			synth_m_q <= 1'b0;
			synth_s_q <= 1'b0;
			synth_p_q <= 1'b0;
		end else begin
			lock_m_q <= core_lock_in;
			lock_s_q <= lock_m_q;
			lock_p_q <= lock_s_q;
			synth_m_q <= core_synth_clk_in;
			synth_s_q <= synth_m_q;
			synth_p_q <= synth_s_q;
		end
	end

	// isolated shifters read as ground, so a powered-off core never looks locked
	assign lock_ok = lock_s_q && !iso;
	assign lock_rise = lock_s_q && !lock_p_q && !iso;
	assign lock_fall = !lock_s_q && lock_p_q && !iso;
	assign synth_tick = synth_s_q && !synth_p_q && !iso;

	// control word: software bits stored, status bits kept out
	always_comb begin
		ctrl_d = ctrl_q;
		if (reg_wr_in) begin
			ctrl_d = reg_wdata_in & pmc_pkg::CTRL_WMASK;
		end
	end

	// lock sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			pmc_pkg::PMC_BYPASS: begin
				if (lock_req) begin
					state_d = pmc_pkg::PMC_LOCKING;
				end
			end
			pmc_pkg::PMC_LOCKING: begin
				if (!lock_req) begin
					state_d = pmc_pkg::PMC_BYPASS;
				end else if (lock_ok) begin
					state_d = pmc_pkg::PMC_LOCKED;
				end
			end
			pmc_pkg::PMC_LOCKED: begin
				if (!lock_req) begin
					state_d = pmc_pkg::PMC_BYPASS;
				end else if (!lock_ok && relock_on_loss) begin
					state_d = pmc_pkg::PMC_BYPASS;
				end
			end
			default: begin
				state_d = pmc_pkg::PMC_BYPASS;
			end
		endcase
		// a write always drops to bypass for one cycle before relocking
		if (reg_wr_in) begin
			state_d = pmc_pkg::PMC_BYPASS;
		end
	end

	// lock-intact flag: the setting event wins over a loss in the same cycle
	always_comb begin
		intact_d = intact_q;
		if (lock_fall && state_q == pmc_pkg::PMC_LOCKED) begin
			intact_d = 1'b0;
		end
		if (reg_wr_in || lock_rise) begin
			intact_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_q <= pmc_pkg::CTRL_RST;
			state_q <= pmc_pkg::PMC_BYPASS;
			intact_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			state_q <= state_d;
			intact_q <= intact_d;
		end
	end

	// drive the core through the level shifters; isolation grounds them
	always_comb begin
		if (iso) begin
			core_enable_out = 1'b0;
			core_mult_out = 5'h00;
			core_div_out = 2'h0;
		end else begin
			core_enable_out = (state_q != pmc_pkg::PMC_BYPASS);
			core_mult_out = feedback_multiplier;
			core_div_out = ref_divider;
		end
	end
	assign core_iso_out = iso;

	// restart both dividers on a write so new ratios start on a clean period
	assign restart_div = reg_wr_in;

	// bypass divider ignores the reference divider field
	pmc_tick_div u_byp_div (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.ratio_in(pmc_pkg::pmc_byp_ratio(byp_div)),
		.restart_in(restart_div),
		.tick_out(tick_byp)
	);

	// unsynthesized lock-mode output: reference over divider code plus one
	pmc_tick_div u_ref_div (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.ratio_in(pmc_pkg::pmc_ref_ratio(ref_divider)),
		.restart_in(restart_div),
		.tick_out(tick_refdiv)
	);

	// lock source: core's multiplied clock, or plain division for codes 0/1
	always_comb begin
		if (feedback_multiplier >= pmc_pkg::MULT_SYNTH_MIN) begin
			tick_lock = synth_tick;
		end else begin
			tick_lock = tick_refdiv;
		end
	end

	// locking and bypass both keep the bypass source selected
	assign lock_sel = (state_q == pmc_pkg::PMC_LOCKED);

	pmc_tick_switch u_switch (
		.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in),
		.sel_in(lock_sel),
		.tick_byp_in(tick_byp),
		.tick_lock_in(tick_lock),
		.tick_out(clkout_en_out),
		.cur_sel_out(clkout_src_out)
	);

	// status readback
	assign lock_status_out = (state_q == pmc_pkg::PMC_LOCKED);
	always_comb begin
		reg_rdata_out = ctrl_q;
		reg_rdata_out[pmc_pkg::INTACT_BIT] = intact_q;
		reg_rdata_out[pmc_pkg::STATUS_BIT] = lock_status_out;
	end
endmodule
`default_nettype wire

// file: verif/pmc_props.sv
// port checker for the loop mode control block
`timescale 1ns/1ps
`default_nettype none
module pmc_props (
	input wire logic clk_sys_in,
	input wire logic resetn_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic core_lock_in,
	input wire logic core_enable_out,
	input wire logic [4:0] core_mult_out,
	input wire logic [1:0] core_div_out,
	input wire logic core_iso_out,
	input wire logic clkout_en_out,
	input wire logic clkout_src_out,
	input wire logic lock_status_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);
	// request write, then a quiet cycle
	sequence req_wr_s;
		reg_wr_in && reg_wdata_in[4] && !reg_wdata_in[15] ##1 !reg_wr_in;
	endsequence
	// five cycles of lock seen while requesting; covers the two sync stages
	sequence held_lock_s;
		(core_enable_out && core_lock_in && !reg_wr_in)[*5];
	endsequence
	status_bit_a: assert property (lock_status_out == reg_rdata_out[0])
		else $error("status bit differs from state");
	write_bypass_a: assert property (reg_wr_in |=> !lock_status_out && !core_enable_out)
		else $error("write did not force bypass");
	write_store_a: assert property (reg_wr_in |=>
		reg_rdata_out[15:1] == {$past(reg_wdata_in[15:2]), 1'b1})
		else $error("stored word wrong after write");
	no_request_a: assert property (!reg_rdata_out[4] |-> !lock_status_out && !core_enable_out)
		else $error("active without request");
	request_start_a: assert property (req_wr_s |=> core_enable_out)
		else $error("locking did not start");
	lock_enter_a: assert property (held_lock_s |-> lock_status_out)
		else $error("lock not entered");
	iso_ground_a: assert property (core_iso_out |-> !core_enable_out && core_mult_out == 5'h00
		&& core_div_out == 2'h0 && reg_rdata_out[15])
		else $error("isolated outputs not grounded");
	field_pass_a: assert property (!core_iso_out |-> core_mult_out == reg_rdata_out[11:7]
		&& core_div_out == reg_rdata_out[6:5])
		else $error("fields not passed to core");
	src_switch_a: assert property ($changed(clkout_src_out) |-> $past(clkout_en_out))
		else $error("source changed between ticks");
endmodule
`default_nettype wire

// file: verif/pll_mode_control_bench.sv
// self-checking bench for the loop mode control block
`timescale 1ns/1ps
`default_nettype none
module pll_mode_control_bench;
	logic clk_sys_in = 1'b0;
	logic resetn_in = 1'b0;
	logic reg_wr_in = 1'b0;
	logic [15:0] reg_wdata_in = 16'h0000;
	logic core_lock_in = 1'b0;
	logic core_synth_clk_in = 1'b0;
	logic [15:0] reg_rdata_out;
	logic core_enable_out, core_iso_out, clkout_en_out, clkout_src_out, lock_status_out;
	logic [4:0] core_mult_out;
	logic [1:0] core_div_out;
	int n_fail = 0;
	int checked = 0;
	int ticks;
	int byp[4] = '{1, 2, 4, 4};
	logic [4:0] lm[4] = '{5'h05, 5'h01, 5'h00, 5'h1f};
	logic [1:0] ld[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	int le[4] = '{6, 16, 12, 6};
	pmc_top dut (.clk_sys_in, .resetn_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
		.core_lock_in, .core_synth_clk_in, .core_enable_out, .core_mult_out, .core_div_out,
		.core_iso_out, .clkout_en_out, .clkout_src_out, .lock_status_out);
	// reference clock, and a core clock of one eighth of it that never stops
	initial forever #10 clk_sys_in = ~clk_sys_in;
	initial forever begin
		repeat (4) @(posedge clk_sys_in);
		#1 core_synth_clk_in = ~core_synth_clk_in;
	end
	function automatic logic [15:0] mk(input logic r, input logic [4:0] m, input logic [1:0] d,
		input logic q, input logic [1:0] b);
		mk = {2'b00, r, 1'b0, m, d, q, b, 2'b00};
	endfunction
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [15:0] d);
		@(posedge clk_sys_in);
		#1 reg_wr_in = 1'b1;
		reg_wdata_in = d;
		@(posedge clk_sys_in);
		#1 reg_wr_in = 1'b0;
	endtask
	// output ticks are combinational, so sample them mid-cycle
	task automatic count(input int n);
		ticks = 0;
		repeat (n) begin
			@(negedge clk_sys_in);
			if (clkout_en_out === 1'b1) ticks++;
		end
	endtask
	// bounded wait for the switch to reach the lock source
	task automatic wait_lock();
		for (int i = 0; i < 100 && clkout_src_out !== 1'b1; i++) @(posedge clk_sys_in);
		#1 check("src", 1, clkout_src_out);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// hang guard at 10000 cycles, well past the few hundred cycles the tests need
	initial begin
		#200000;
		n_fail++;
		complete_run();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys_in);
		#1 resetn_in = 1'b1;
		check("rdata", 16'h2000, reg_rdata_out);
		check("status", 0, lock_status_out);
		$display("test reset done");
		// lock divider at maximum must not touch bypass rate
		for (int c = 0; c < 4; c++) begin
			wr(mk(1'b1, 5'h04, 2'h3, 1'b0, c[1:0]));
			count(32);
			check("bypass ticks", 32 / byp[c], ticks);
		end
		$display("test bypass done");
		for (int k = 0; k < 4; k++) begin
			core_lock_in = 1'b0;
			// the switch leaves the lock source only on its own tick, so let it settle first
			for (int i = 0; i < 100 && clkout_src_out !== 1'b0; i++) @(posedge clk_sys_in);
			wr(mk(1'b1, lm[k], ld[k], 1'b1, 2'h1));
			check("mult", lm[k], core_mult_out);
			check("div", ld[k], core_div_out);
			count(16);
			check("locking ticks", 8, ticks);
			check("status", 0, lock_status_out);
			core_lock_in = 1'b1;
			wait_lock();
			check("status", 1, reg_rdata_out[0]);
			count(48);
			check("lock ticks", le[k], ticks);
		end
		$display("test lock done");
		core_lock_in = 1'b0;
		repeat (12) @(posedge clk_sys_in);
		#1 check("lost", 0, reg_rdata_out[1:0]);
		check("relocking", 1, core_enable_out);
		core_lock_in = 1'b1;
		wait_lock();
		check("restored", 3, reg_rdata_out[1:0]);
		wr(mk(1'b0, 5'h03, 2'h0, 1'b1, 2'h2));
		// give the switch time to drop back to bypass before waiting for lock again
		repeat (12) @(posedge clk_sys_in);
		wait_lock();
		core_lock_in = 1'b0;
		repeat (12) @(posedge clk_sys_in);
		#1 check("held", 1, reg_rdata_out[1:0]);
		wr(16'h0003 | mk(1'b1, 5'h03, 2'h0, 1'b0, 2'h0));
		check("rewrite", 16'h0002 | mk(1'b1, 5'h03, 2'h0, 1'b0, 2'h0), reg_rdata_out);
		$display("test loss done");
		wr(16'h8000 | mk(1'b1, 5'h07, 2'h2, 1'b1, 2'h0));
		check("iso", 1, core_iso_out);
		check("mult iso", 0, core_mult_out);
		resetn_in = 1'b0;
		#40 resetn_in = 1'b1;
		check("rdata", 16'h2000, reg_rdata_out);
		$display("test isolation done");
		complete_run();
	end
endmodule
bind pmc_top pmc_props props_i (.clk_sys_in, .resetn_in, .reg_wr_in, .reg_wdata_in,
	.reg_rdata_out, .core_lock_in, .core_enable_out, .core_mult_out, .core_div_out,
	.core_iso_out, .clkout_en_out, .clkout_src_out, .lock_status_out);
`default_nettype wire
